//--- hw/lsia_sticky.sv
`timescale 1ns/1ps
// Eight sticky event flags; a set in the clearing cycle wins.
module lsia_sticky
	import lsia_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// Events and clears.
	input  wire logic [7:0]  set_i,
	input  wire logic [7:0]  clr_i,
	// Flags.
	output logic      [7:0]  q_o
);
	logic [7:0] q_r;
	logic [7:0] q_nxt;

	// Set is ORed in after the clear so a coincident event is kept.
	always_comb begin
		q_nxt = (q_r & ~clr_i) | set_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			q_r <= RST_STATUS;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign q_o = q_r;
endmodule

//--- hw/lsia_top.sv
`timescale 1ns/1ps
// Interrupt aggregator with a parallel non-multiplexed host port.
module lsia_top
	import lsia_pkg::*;
(
	// Clock and reset.
	input  wire logic        CLK_I,
	input  wire logic        RSTN_I,
	// Control-mode strap.
	input  wire logic [1:0]  MODE_I,
	// Host parallel port pins.
	input  wire logic        CS_N_I,
	input  wire logic [5:0]  ADDR_I,
	input  wire logic        DS_RD_N_I,
	input  wire logic        RW_WR_N_I,
	input  wire logic [7:0]  DATA_I,
	output logic      [7:0]  DATA_O,
	output logic             DATA_OE_O,
	// Interrupt sources, one-cycle pulses from on-chip logic.
	input  wire logic [7:0]  EVT_A_I,
	input  wire logic [7:0]  EVT_B_I,
	// Interrupt request pin.
	output logic             INT_O,
	output logic             INT_OE_O
);
	// Two-stage synchronisers for the pins.
	logic [1:0]  mode_s1_r, mode_s2_r;
	logic        cs_s1_r, cs_s2_r;
	logic [5:0]  addr_s1_r, addr_s2_r;
	logic        ds_s1_r, ds_s2_r;
	logic        rw_s1_r, rw_s2_r;
	logic [7:0]  din_s1_r, din_s2_r;

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			mode_s1_r <= MODE_HARDWARE;
			mode_s2_r <= MODE_HARDWARE;
			cs_s1_r   <= 1'b1;
			cs_s2_r   <= 1'b1;
			addr_s1_r <= 6'h00;
			addr_s2_r <= 6'h00;
			ds_s1_r   <= 1'b1;
			ds_s2_r   <= 1'b1;
			rw_s1_r   <= 1'b1;
			rw_s2_r   <= 1'b1;
			din_s1_r  <= 8'h00;
			din_s2_r  <= 8'h00;
		end else begin
			mode_s1_r <= MODE_I;
			mode_s2_r <= mode_s1_r;
			cs_s1_r   <= CS_N_I;
			cs_s2_r   <= cs_s1_r;
			addr_s1_r <= ADDR_I;
			addr_s2_r <= addr_s1_r;
			ds_s1_r   <= DS_RD_N_I;
			ds_s2_r   <= ds_s1_r;
			rw_s1_r   <= RW_WR_N_I;
			rw_s2_r   <= rw_s1_r;
			din_s1_r  <= DATA_I;
			din_s2_r  <= din_s1_r;
		end
	end

	// Decoded access phases from the synchronised pins.
	logic par_mode;
	logic rd_act;
	logic wr_act;

	always_comb begin
		par_mode = (mode_s2_r == MODE_PAR_DS) || (mode_s2_r == MODE_PAR_RDWR);
		if (mode_s2_r == MODE_PAR_RDWR) begin
			rd_act = ~ds_s2_r;
			wr_act = ~rw_s2_r;
		end else begin
			rd_act = ~ds_s2_r & rw_s2_r;
			wr_act = ~ds_s2_r & ~rw_s2_r;
		end
		rd_act = rd_act & ~cs_s2_r & par_mode;
		wr_act = wr_act & ~cs_s2_r & par_mode;
	end

	// Register state.
	logic [7:0] mask_a_r, mask_a_nxt;
	logic [7:0] mask_b_r, mask_b_nxt;
	logic [7:0] cfg_r, cfg_nxt;
	logic       rd_act_r, wr_act_r;
	logic [5:0] rd_addr_r, rd_addr_nxt;
	logic [7:0] rd_snap_r, rd_snap_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic       doe_r, doe_nxt;
	logic [7:0] clr_a, clr_b;
	logic [7:0] status_a, status_b;
	logic [7:0] pend_a, pend_b;
	logic [7:0] summary;
	logic [7:0] rd_mux;

	// Status flags; events arriving during a read survive the clear.
	lsia_sticky u_status_a (
		.clk_i  (CLK_I),
		.rstn_i (RSTN_I),
		.set_i  (EVT_A_I),
		.clr_i  (clr_a),
		.q_o    (status_a)
	);

	lsia_sticky u_status_b (
		.clk_i  (CLK_I),
		.rstn_i (RSTN_I),
		.set_i  (EVT_B_I),
		.clr_i  (clr_b),
		.q_o    (status_b)
	);

	// Pending sources after per-source masking, and the channel summary.
	always_comb begin
		pend_a  = status_a & ~mask_a_r;
		pend_b  = status_b & ~mask_b_r;
		summary = {6'h00, |pend_b, |pend_a};
	end

	// Read multiplexer; unmapped offsets read as zero.
	always_comb begin
		unique case (addr_s2_r)
			OFS_SOURCE_MASK_A:      rd_mux = mask_a_r;
			OFS_SOURCE_MASK_B:      rd_mux = mask_b_r;
			OFS_SOURCE_STATUS_A:    rd_mux = status_a;
			OFS_SOURCE_STATUS_B:    rd_mux = status_b;
			OFS_GLOBAL_CONFIG:      rd_mux = cfg_r;
			OFS_CHANNEL_EVENT_SUMM: rd_mux = summary;
			default:                rd_mux = 8'h00;
		endcase
	end

	// Port next state. Writes land at the trailing edge of the strobe, when data is settled.
	// Status is cleared at the end of a read, but only the bits the host actually saw.
	always_comb begin
		mask_a_nxt  = mask_a_r;
		mask_b_nxt  = mask_b_r;
		cfg_nxt     = cfg_r;
		rd_addr_nxt = rd_addr_r;
		rd_snap_nxt = rd_snap_r;
		dout_nxt    = dout_r;
		doe_nxt     = rd_act;
		clr_a       = 8'h00;
		clr_b       = 8'h00;
		if (rd_act && !rd_act_r) begin
			rd_addr_nxt = addr_s2_r;
			rd_snap_nxt = rd_mux;
			dout_nxt    = rd_mux;
		end
		if (!rd_act && rd_act_r) begin
			if (rd_addr_r == OFS_SOURCE_STATUS_A) begin
				clr_a = rd_snap_r;
			end
			if (rd_addr_r == OFS_SOURCE_STATUS_B) begin
				clr_b = rd_snap_r;
			end
		end
		if (!wr_act && wr_act_r && !cs_s2_r) begin
			unique case (addr_s2_r)
				OFS_SOURCE_MASK_A: mask_a_nxt = din_s2_r;
				OFS_SOURCE_MASK_B: mask_b_nxt = din_s2_r;
				OFS_GLOBAL_CONFIG: cfg_nxt = din_s2_r;
				default:           cfg_nxt = cfg_r;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			mask_a_r  <= RST_SOURCE_MASK;
			mask_b_r  <= RST_SOURCE_MASK;
			cfg_r     <= RST_GLOBAL_CONFIG;
			rd_act_r  <= 1'b0;
			wr_act_r  <= 1'b0;
			rd_addr_r <= 6'h00;
			rd_snap_r <= 8'h00;
			dout_r    <= 8'h00;
			doe_r     <= 1'b0;
		end else begin
			mask_a_r  <= mask_a_nxt;
			mask_b_r  <= mask_b_nxt;
			cfg_r     <= cfg_nxt;
			rd_act_r  <= rd_act;
			wr_act_r  <= wr_act;
			rd_addr_r <= rd_addr_nxt;
			rd_snap_r <= rd_snap_nxt;
			dout_r    <= dout_nxt;
			doe_r     <= doe_nxt;
		end
	end

	// Request and pin drive. The pin is idle in hardware mode, where no registers exist.
	logic       req;
	logic [1:0] drv;
	logic       int_r, int_nxt;
	logic       int_oe_r, int_oe_nxt;

	always_comb begin
		req = (|pend_a | |pend_b) & ~cfg_r[CFG_GLOBAL_MASK_BIT] & par_mode;
		drv = cfg_r[CFG_PIN_DRIVE_LSB +: 2];
		unique case (drv)
			DRV_PP_HIGH: begin
				int_nxt    = req;
				int_oe_nxt = 1'b1;
			end
			DRV_PP_LOW: begin
				int_nxt    = ~req;
				int_oe_nxt = 1'b1;
			end
			default: begin
				int_nxt    = 1'b0;
				int_oe_nxt = req;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			int_r    <= 1'b0;
			int_oe_r <= 1'b1;
		end else begin
			int_r    <= int_nxt;
			int_oe_r <= int_oe_nxt;
		end
	end

	assign DATA_O    = dout_r;
	assign DATA_OE_O = doe_r;
	assign INT_O     = int_r;
	assign INT_OE_O  = int_oe_r;
endmodule

//--- pkg/lsia_pkg.sv
package lsia_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [5:0] OFS_SOURCE_MASK_A      = 6'h13;
	localparam logic [5:0] OFS_SOURCE_MASK_B      = 6'h14;
	localparam logic [5:0] OFS_SOURCE_STATUS_A    = 6'h18;
	localparam logic [5:0] OFS_SOURCE_STATUS_B    = 6'h19;
	localparam logic [5:0] OFS_GLOBAL_CONFIG      = 6'h20;
	localparam logic [5:0] OFS_CHANNEL_EVENT_SUMM = 6'h21;

	// Field positions in global_config.
	localparam int CFG_GLOBAL_MASK_BIT = 0;
	localparam int CFG_PIN_DRIVE_LSB   = 1;

	// Values after reset.
	localparam logic [7:0] RST_SOURCE_MASK   = 8'hff;
	localparam logic [7:0] RST_GLOBAL_CONFIG = 8'h01;
	localparam logic [7:0] RST_STATUS        = 8'h00;

	// Pin-drive encodings.
	localparam logic [1:0] DRV_PP_HIGH = 2'h0;
	localparam logic [1:0] DRV_PP_LOW  = 2'h1;

	// Control-mode strap encodings.
	localparam logic [1:0] MODE_HARDWARE = 2'h0;
	localparam logic [1:0] MODE_SERIAL   = 2'h1;
	localparam logic [1:0] MODE_PAR_DS   = 2'h2;
	localparam logic [1:0] MODE_PAR_RDWR = 2'h3;
endpackage

//--- verification/lsia_assertions.sv
`timescale 1ns/1ps
// Watches the host port and the request pin from the outside only.
module lsia_assertions (
	// Clock, reset and strap.
	input  wire logic       CLK_I,
	input  wire logic       RSTN_I,
	input  wire logic [1:0] MODE_I,
	// Host port.
	input  wire logic       CS_N_I,
	input  wire logic       DS_RD_N_I,
	input  wire logic [7:0] DATA_O,
	input  wire logic       DATA_OE_O,
	// Request pin.
	input  wire logic       INT_O,
	input  wire logic       INT_OE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	// Five held cycles clear the two sync stages and the output register.
	sequence rd_held_s;
		(!CS_N_I && !DS_RD_N_I && MODE_I == 2'h3) [*5];
	endsequence
	rd_drive_a: assert property (rd_held_s |-> DATA_OE_O) else $error("read data not driven");
	rd_release_a: assert property ($rose(DS_RD_N_I) |-> ##[1:4] !DATA_OE_O) else $error("bus held");
	rd_stand_a: assert property (DATA_OE_O && $past(DATA_OE_O) |-> $stable(DATA_O)) else $error("data moved");
	cs_idle_a: assert property (CS_N_I [*5] |-> !DATA_OE_O) else $error("driven while unselected");
	hw_mode_a: assert property ((MODE_I == 2'h0) [*5] |-> !DATA_OE_O) else $error("driven in pin mode");
	serial_mode_a: assert property ((MODE_I == 2'h1) [*5] |-> !DATA_OE_O) else $error("driven in serial mode");
	no_read_a: assert property ((DS_RD_N_I && MODE_I == 2'h3) [*5] |-> !DATA_OE_O) else $error("driven idle");
	od_drive_a: assert property (!INT_OE_O |-> !INT_O) else $error("request high while undriven");
	rst_int_a: assert property ($rose(RSTN_I) |-> !INT_O && INT_OE_O && !DATA_OE_O) else $error("bad reset");
endmodule

//--- verification/lsia_host_model.sv
`timescale 1ns/1ps
// Host on either style of parallel port; pins move only just after a rising edge.
module lsia_host_model (
	// Clock and bus style.
	input  wire logic       clk_i,
	input  wire logic       ds_style_i,
	// Read data from the device.
	input  wire logic [7:0] rdata_i,
	input  wire logic       oe_i,
	// Port pins towards the device.
	output logic            cs_n_o,
	output logic [5:0]      addr_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic [7:0]      data_o
);
	initial {cs_n_o, rd_n_o, wr_n_o, addr_o, data_o} = 17'h1ff5a;
	// Select outlasts the strobe by a cycle so the write edge is seen while selected.
	task automatic acc(input logic sel, input logic wr, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		cs_n_o <= !sel;
		addr_o <= a;
		data_o <= d;
		// In the strobe style a write is the data strobe with read/not-write low.
		if (wr) begin
			wr_n_o <= 1'b0;
			rd_n_o <= !ds_style_i;
		end else begin
			rd_n_o <= 1'b0;
		end
		repeat (5) @(posedge clk_i);
		// An undriven bus reads as unknown, so a silent device cannot pass as a zero.
		q = (oe_i === 1'b1) ? rdata_i : 8'hxx;
		{rd_n_o, wr_n_o} <= 2'h3;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		data_o <= ~d; // Released lines keep changing.
		repeat (4) @(posedge clk_i);
	endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin mismatches++; $display("FAIL %0t %s", $time, m); end end
module testbench;
	import lsia_pkg::*;
	logic        clk = 0, rstn = 0, cs_n, rd_n, wr_n, data_oe, int_o, int_oe;
	logic [1:0]  mode = 2'h3;
	logic [5:0]  addr;
	logic [7:0]  evt_a = 0, evt_b = 0, q, wdata, rdata;
	logic [31:0] seed = 32'h21cc93fe;
	int          mismatches = 0, cmp_count = 0, ma = 'hff, mb = 'hff, gc = 1, sa = 0, sb = 0;
	always #50 clk = ~clk;
	lsia_top i_lsia_top (.CLK_I(clk), .RSTN_I(rstn), .MODE_I(mode), .CS_N_I(cs_n), .ADDR_I(addr), .DS_RD_N_I(rd_n),
		.RW_WR_N_I(wr_n), .DATA_I(wdata), .DATA_O(rdata), .DATA_OE_O(data_oe), .EVT_A_I(evt_a), .EVT_B_I(evt_b),
		.INT_O(int_o), .INT_OE_O(int_oe));
	lsia_host_model i_lsia_host_model (.clk_i(clk), .ds_style_i(mode == MODE_PAR_DS), .rdata_i(rdata), .oe_i(data_oe),
		.cs_n_o(cs_n), .addr_o(addr),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(wdata));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wr(input logic [5:0] a, input int d);
		i_lsia_host_model.acc(1'b1, 1'b1, a, d[7:0], q);
	endtask
	task automatic rd(input logic [5:0] a, input int e, input string m);
		i_lsia_host_model.acc(1'b1, 1'b0, a, 8'h00, q);
		`CHK(q, e[7:0], m)
	endtask
	// Request level from the model; open drain only pulls low when asserted.
	task automatic chk_int(input string m);
		logic req;
		req = !gc[0] && (((sa & ~ma) | (sb & ~mb)) & 'hff) != 0;
		`CHK({int_o, int_oe}, gc[2] ? {1'b0, req} : {req ^ gc[1], 1'b1}, m)
	endtask
	task automatic conclude();
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence: every drive style with the global mask both ways.
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(OFS_SOURCE_MASK_B, 'hff, "mask reset");
		rd(OFS_GLOBAL_CONFIG, 1, "config reset");
		rd(6'h3f, 0, "unmapped");
		for (int i = 0; i < 8; i++) begin
			ma = rnd() & rnd() & 'hff;
			mb = rnd() & rnd() & 'hff;
			gc = i;
			wr(OFS_SOURCE_MASK_A, ma);
			wr(OFS_SOURCE_MASK_B, mb);
			wr(OFS_GLOBAL_CONFIG, gc);
			wr(OFS_SOURCE_STATUS_A, 'hff);
			rd(OFS_SOURCE_MASK_A, ma, "mask a");
			rd(OFS_GLOBAL_CONFIG, gc, "config");
			chk_int("idle request");
			@(posedge clk);
			evt_a <= 8'(rnd());
			evt_b <= 8'(rnd());
			@(posedge clk);
			sa |= evt_a;
			sb |= evt_b;
			evt_a <= 8'h00;
			evt_b <= 8'h00;
			repeat (6) @(posedge clk);
			chk_int("raised request");
			rd(OFS_CHANNEL_EVENT_SUMM, {(sb & ~mb & 'hff) != 0, (sa & ~ma & 'hff) != 0}, "summary");
			rd(OFS_SOURCE_STATUS_A, sa, "status a");
			sa = 0;
			rd(OFS_SOURCE_STATUS_B, sb, "status b");
			sb = 0;
			chk_int("released request");
		end
		mode <= 2'h0;
		wr(OFS_SOURCE_MASK_A, 0);
		mode <= 2'h3;
		i_lsia_host_model.acc(1'b0, 1'b1, OFS_SOURCE_MASK_A, 8'h00, q);
		rd(OFS_SOURCE_MASK_A, ma, "refused writes");
		// The serial strap must refuse the parallel port; the strobe style must then work.
		mode <= MODE_SERIAL;
		wr(OFS_SOURCE_MASK_A, 'h0f);
		mode <= MODE_PAR_DS;
		rd(OFS_SOURCE_MASK_A, ma, "serial refused");
		ma = rnd() & 'hff;
		wr(OFS_SOURCE_MASK_A, ma);
		rd(OFS_SOURCE_MASK_A, ma, "strobe style");
		conclude();
	end
	// Watchdog well beyond the expected run of some 990 cycles.
	initial begin
		#1000000;
		mismatches++;
		conclude();
	end
endmodule
bind lsia_top lsia_assertions i_lsia_assertions (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .MODE_I(MODE_I), .CS_N_I(CS_N_I),
	.DS_RD_N_I(DS_RD_N_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .INT_O(INT_O), .INT_OE_O(INT_OE_O));
